// file: rtl/usc_bit_timer.sv
// bit pacing: internal divider, or edges of the external synchronous clock
// assumes sync_clock_pin is already synchronous to sys_clk
module usc_bit_timer import usc_pkg::*; #(
   parameter int DIV_W = 16,
   parameter bit SYNC_RISE = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic sync_mode,
   input wire logic sync_clock_pin,
   input wire logic restart,
   input wire logic [DIV_W-1:0] divisor,
   output logic tick
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic pin_prev;
   } usc_tmr_t;

   usc_tmr_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.pin_prev = sync_clock_pin;
      if (sync_mode) begin
         tick = SYNC_RISE ? (sync_clock_pin & ~s_reg.pin_prev)
                          : (~sync_clock_pin & s_reg.pin_prev);
      end else begin
         tick = (s_reg.cnt == '0) & ~restart;
      end
      // restart lands the next tick in mid-bit for start-bit sampling
      if (restart) begin
         s_next.cnt = divisor >> 1;
      end else if (s_reg.cnt == '0) begin
         s_next.cnt = divisor;
      end else begin
         s_next.cnt = s_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule // usc_bit_timer

// file: rtl/usc_cfg.svh
// register map, field positions, reset values and encodings of the serial block
// assumes an 8-bit register view placed in the low lane of a 32-bit APB word
`ifndef USC_CFG_SVH
`define USC_CFG_SVH

`define USC_ADDR_W 8
`define USC_OFF_DATA 8'h00
`define USC_OFF_STATUS 8'h04
`define USC_OFF_CTRL 8'h08
`define USC_OFF_FRAME 8'h0c
`define USC_OFF_BAUD 8'h10

// serial_status_reg bits
`define USC_ST_RX_DONE 7
`define USC_ST_TX_DONE 6
`define USC_ST_TX_EMPTY 5
`define USC_ST_FRAME_ERR 4
`define USC_ST_OVERRUN 3
`define USC_ST_PARITY_ERR 2

// serial_control_reg bits
`define USC_CT_RX_IRQ_EN 7
`define USC_CT_TX_DONE_IRQ_EN 6
`define USC_CT_TX_EMPTY_IRQ_EN 5
`define USC_CT_RECEIVER_ON 4
`define USC_CT_TRANSMITTER_ON 3
`define USC_CT_CHAR_SIZE_HI 2
`define USC_CT_RX_NINTH 1
`define USC_CT_TX_NINTH 0

// frame register bits
`define USC_FR_SYNC_MODE 6
`define USC_FR_PARITY_EN 5
`define USC_FR_PARITY_ODD 4
`define USC_FR_TWO_STOP 3
`define USC_FR_CHAR_SIZE_LO 1

`define USC_CTRL_RESET 8'h00
`define USC_FRAME_RESET 7'h06
`define USC_BAUD_RESET 16'h0067
`define USC_CHAR_SIZE_NINE 3'h7
`define USC_MIN_DATA_BITS 4'h5
`define USC_NINE_DATA_BITS 4'h9

`endif

// file: rtl/usc_pkg.sv
// types shared by the serial block modules
// assumes usc_cfg.svh supplies the numeric constants
package usc_pkg;

   typedef enum logic [5:0] {
      USC_TX_IDLE = 6'b000001,
      USC_TX_DATA = 6'b000010,
      USC_TX_PAR = 6'b000100,
      USC_TX_STOP = 6'b001000,
      USC_TX_STOP2 = 6'b010000,
      USC_TX_LAST = 6'b100000
   } usc_tx_state_t;

   typedef enum logic [4:0] {
      USC_RX_IDLE = 5'b00001,
      USC_RX_START = 5'b00010,
      USC_RX_DATA = 5'b00100,
      USC_RX_PAR = 5'b01000,
      USC_RX_STOP = 5'b10000
   } usc_rx_state_t;

   // one receive buffer entry: character plus its own status
   typedef struct packed {
      logic [8:0] data;
      logic frame_error_flag;
      logic overrun_flag;
      logic parity_error_flag;
   } usc_entry_t;

endpackage

// file: rtl/usc_rx_fifo.sv
// receive buffer fifo holding characters with their status bits
// assumes the caller never pushes while full
module usc_rx_fifo import usc_pkg::*; #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head,
   output logic empty,
   output logic full
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] rd;
      logic [PW-1:0] wr;
      logic [PW:0] count;
   } usc_fifo_t;

   usc_fifo_t s_reg, s_next;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign head = s_reg.mem[s_reg.rd];
   assign empty = (s_reg.count == '0);
   assign full = (s_reg.count == (PW + 1)'(DEPTH));

   always_comb begin
      s_next = s_reg;
      if (flush) begin
         s_next.rd = '0;
         s_next.wr = '0;
         s_next.count = '0;
      end else begin
         if (push && !full) begin
            s_next.mem[s_reg.wr] = push_data;
            s_next.wr = bump(s_reg.wr);
         end
         if (pop && !empty) begin
            s_next.rd = bump(s_reg.rd);
         end
         s_next.count = s_reg.count + (PW + 1)'(push && !full) - (PW + 1)'(pop && !empty);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule // usc_rx_fifo

// file: rtl/usc_serial.sv
// serial transmitter completion logic, receive datapath and APB register file
// assumes APB master on sys_clk; serial pins synchronous to sys_clk
//
// The implementer's own choices: register access over APB and the address map.
`include "usc_cfg.svh"

// Functional notes
// - done flag when shifter and buffer empty
// - done flag clears on ack or write-one
// - done interrupt needs enable and global enable
// - parity bit after data, before stop
// - transmitter off waits for buffer and shifter
// - disabled transmitter releases output pin
// - receiver enable claims serial input pin
// - sync mode paces receiver by external clock
// - frame starts on valid start bit
// - stop at first stop bit
// - completed frame moves into receive buffer
// - unused upper data bits read zero
// - ninth bit readable, read before data
// - status stored per entry, pops on read
// - empty flag set when buffer empty
// - receive flag shows unread data present
// - two-deep buffer plus holding slot, overrun on fourth start
// - receiver off flushes everything at once
module usc_serial import usc_pkg::*; #(
   parameter int BAUD_W = 16,
   parameter int RX_DEPTH = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`USC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_enable,
   input wire logic tx_done_irq_ack,
   input wire logic sync_clock_pin,
   input wire logic rxd_in,
   output logic txd_out,
   output logic txd_oe,
   output logic rx_pin_owned,
   output logic tx_empty_irq,
   output logic tx_done_irq,
   output logic rx_done_irq
);

   typedef struct packed {
      logic [7:0] rdata;
      logic ready;
      logic slverr;
      logic [7:0] ctrl;
      logic [6:0] frame;
      logic [BAUD_W-1:0] baud;
      logic [8:0] tbuf;
      logic tbuf_full;
      logic [8:0] tsh;
      logic tpar;
      usc_tx_state_t tst;
      logic [3:0] tcnt;
      logic txd;
      logic tx_act;
      logic tx_done;
      usc_rx_state_t rst;
      logic [3:0] rcnt;
      logic [8:0] rsh;
      logic rpe;
      logic rxd_prev;
      usc_entry_t pend;
      logic pend_v;
      logic ovr;
      logic rx_own;
      logic irq_te;
      logic irq_td;
      logic irq_rc;
   } usc_state_t;

   usc_state_t s_reg, s_next;

   // data bits per character from the three-bit size code
   function automatic logic [3:0] data_bits(input logic [2:0] cs);
      if (cs == `USC_CHAR_SIZE_NINE) begin
         data_bits = `USC_NINE_DATA_BITS;
      end else begin
         data_bits = `USC_MIN_DATA_BITS + {2'b00, cs[1:0]};
      end
   endfunction

   function automatic logic [8:0] char_mask(input logic [3:0] n);
      char_mask = 9'(({9'h000, 1'b1} << n) - 10'h001);
   endfunction

   function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
                                      input logic odd);
      parity_of = (^(d & char_mask(n))) ^ odd;
   endfunction

   logic [2:0] char_size;
   logic [3:0] nbits;
   logic [8:0] mask;
   logic par_en;
   logic par_odd;
   logic two_stop;
   logic sync_mode;
   logic receiver_on;
   logic transmitter_on;
   logic tx_tick;
   logic rx_tick;
   logic rx_restart;
   logic fifo_push;
   logic fifo_pop;
   logic fifo_flush;
   logic fifo_empty;
   logic fifo_full;
   usc_entry_t fifo_in;
   usc_entry_t fifo_head;
   logic setup;
   logic access;

   assign char_size = {s_reg.ctrl[`USC_CT_CHAR_SIZE_HI],
                       s_reg.frame[`USC_FR_CHAR_SIZE_LO +: 2]};
   assign nbits = data_bits(char_size);
   assign mask = char_mask(nbits);
   assign par_en = s_reg.frame[`USC_FR_PARITY_EN];
   assign par_odd = s_reg.frame[`USC_FR_PARITY_ODD];
   assign two_stop = s_reg.frame[`USC_FR_TWO_STOP];
   assign sync_mode = s_reg.frame[`USC_FR_SYNC_MODE];
   assign receiver_on = s_reg.ctrl[`USC_CT_RECEIVER_ON];
   assign transmitter_on = s_reg.ctrl[`USC_CT_TRANSMITTER_ON];
   assign setup = psel & ~penable;
   assign access = psel & penable & s_reg.ready;

   // transmitter shifts on the falling edge of the external clock
   usc_bit_timer #(.DIV_W(BAUD_W), .SYNC_RISE(1'b0)) u_tx_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .sync_mode(sync_mode),
      .sync_clock_pin(sync_clock_pin),
      .restart(1'b0),
      .divisor(s_reg.baud),
      .tick(tx_tick)
   );

   // receiver samples on the rising edge, mid-bit in async mode
   usc_bit_timer #(.DIV_W(BAUD_W), .SYNC_RISE(1'b1)) u_rx_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .sync_mode(sync_mode),
      .sync_clock_pin(sync_clock_pin),
      .restart(rx_restart),
      .divisor(s_reg.baud),
      .tick(rx_tick)
   );

   usc_rx_fifo #(.WIDTH($bits(usc_entry_t)), .DEPTH(RX_DEPTH)) u_rx_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .flush(fifo_flush),
      .push(fifo_push),
      .push_data(fifo_in),
      .pop(fifo_pop),
      .head(fifo_head),
      .empty(fifo_empty),
      .full(fifo_full)
   );

   always_comb begin
      usc_entry_t done_char;
      logic frame_done;
      s_next = s_reg;
      done_char = '0;
      frame_done = 1'b0;
      fifo_push = 1'b0;
      fifo_in = s_reg.pend;
      fifo_pop = 1'b0;
      fifo_flush = 1'b0;
      rx_restart = 1'b0;

      // apb: zero wait states, answer registered from the setup cycle
      s_next.ready = setup;
      s_next.slverr = 1'b0;
      if (setup) begin
         s_next.rdata = 8'h00;
         case (paddr)
            `USC_OFF_DATA: begin
               if (!fifo_empty) begin
                  s_next.rdata = fifo_head.data[7:0];
               end
            end
            `USC_OFF_STATUS: begin
               s_next.rdata[`USC_ST_RX_DONE] = ~fifo_empty;
               s_next.rdata[`USC_ST_TX_DONE] = s_reg.tx_done;
               s_next.rdata[`USC_ST_TX_EMPTY] = ~s_reg.tbuf_full;
               if (!fifo_empty) begin
                  s_next.rdata[`USC_ST_FRAME_ERR] = fifo_head.frame_error_flag;
                  s_next.rdata[`USC_ST_OVERRUN] = fifo_head.overrun_flag;
                  s_next.rdata[`USC_ST_PARITY_ERR] = fifo_head.parity_error_flag;
               end
            end
            `USC_OFF_CTRL: begin
               s_next.rdata = s_reg.ctrl;
               s_next.rdata[`USC_CT_RX_NINTH] = ~fifo_empty & fifo_head.data[8];
            end
            `USC_OFF_FRAME: begin
               s_next.rdata = {1'b0, s_reg.frame};
            end
            `USC_OFF_BAUD: begin
               s_next.rdata = s_reg.baud[7:0];
            end
            default: begin
               s_next.slverr = 1'b1;
            end
         endcase
      end

      if (access && pwrite) begin
         case (paddr)
            `USC_OFF_DATA: begin
               // narrow characters drop the unused upper bits
               s_next.tbuf = {s_reg.ctrl[`USC_CT_TX_NINTH], pwdata[7:0]} & mask;
               s_next.tbuf_full = 1'b1;
            end
            `USC_OFF_STATUS: begin
               if (pwdata[`USC_ST_TX_DONE]) begin
                  s_next.tx_done = 1'b0;
               end
            end
            `USC_OFF_CTRL: begin
               s_next.ctrl = pwdata[7:0];
            end
            `USC_OFF_FRAME: begin
               s_next.frame = pwdata[6:0];
            end
            `USC_OFF_BAUD: begin
               s_next.baud = pwdata[BAUD_W-1:0];
            end
            default: begin
            end
         endcase
      end
      if (access && !pwrite && paddr == `USC_OFF_DATA) begin
         fifo_pop = 1'b1;
      end
      if (tx_done_irq_ack) begin
         s_next.tx_done = 1'b0;
      end

      // transmitter stays active until nothing is left to send
      if (transmitter_on) begin
         s_next.tx_act = 1'b1;
      end else if (s_reg.tst == USC_TX_IDLE && !s_reg.tbuf_full) begin
         s_next.tx_act = 1'b0;
      end

      if (tx_tick) begin
         case (s_reg.tst)
            USC_TX_IDLE, USC_TX_LAST: begin
               if (s_reg.tbuf_full && s_reg.tx_act) begin
                  s_next.tsh = s_reg.tbuf;
                  s_next.tpar = parity_of(s_reg.tbuf, nbits, par_odd);
                  s_next.tbuf_full = 1'b0;
                  s_next.txd = 1'b0;
                  s_next.tcnt = 4'h0;
                  s_next.tst = USC_TX_DATA;
               end else begin
                  s_next.txd = 1'b1;
                  s_next.tst = USC_TX_IDLE;
                  if (s_reg.tst == USC_TX_LAST) begin
                     s_next.tx_done = 1'b1;
                  end
               end
            end
            USC_TX_DATA: begin
               s_next.txd = s_reg.tsh[0];
               s_next.tsh = s_reg.tsh >> 1;
               s_next.tcnt = s_reg.tcnt + 4'h1;
               if (s_reg.tcnt == nbits - 4'h1) begin
                  s_next.tst = par_en ? USC_TX_PAR : USC_TX_STOP;
               end
            end
            USC_TX_PAR: begin
               s_next.txd = s_reg.tpar;
               s_next.tst = USC_TX_STOP;
            end
            USC_TX_STOP: begin
               s_next.txd = 1'b1;
               s_next.tst = two_stop ? USC_TX_STOP2 : USC_TX_LAST;
            end
            USC_TX_STOP2: begin
               s_next.txd = 1'b1;
               s_next.tst = USC_TX_LAST;
            end
            default: begin
               s_next.txd = 1'b1;
               s_next.tst = USC_TX_IDLE;
            end
         endcase
      end

      // receiver
      s_next.rx_own = receiver_on;
      s_next.rxd_prev = rxd_in;
      case (s_reg.rst)
         USC_RX_IDLE: begin
            if (!sync_mode && s_reg.rxd_prev && !rxd_in) begin
               rx_restart = 1'b1;
               s_next.rst = USC_RX_START;
            end else if (sync_mode && rx_tick && !rxd_in) begin
               s_next.rst = USC_RX_DATA;
            end
         end
         USC_RX_START: begin
            if (rx_tick) begin
               // a glitch shorter than half a bit is not a start bit
               s_next.rst = rxd_in ? USC_RX_IDLE : USC_RX_DATA;
            end
         end
         USC_RX_DATA: begin
            if (rx_tick) begin
               s_next.rsh[s_reg.rcnt] = rxd_in;
               s_next.rcnt = s_reg.rcnt + 4'h1;
               if (s_reg.rcnt == nbits - 4'h1) begin
                  s_next.rst = par_en ? USC_RX_PAR : USC_RX_STOP;
               end
            end
         end
         USC_RX_PAR: begin
            if (rx_tick) begin
               s_next.rpe = rxd_in ^ parity_of(s_reg.rsh, nbits, par_odd);
               s_next.rst = USC_RX_STOP;
            end
         end
         USC_RX_STOP: begin
            if (rx_tick) begin
               // a second stop bit just looks like idle line
               frame_done = 1'b1;
               done_char.data = s_reg.rsh;
               done_char.frame_error_flag = ~rxd_in;
               done_char.parity_error_flag = s_reg.rpe;
               s_next.rst = USC_RX_IDLE;
            end
         end
         default: begin
            s_next.rst = USC_RX_IDLE;
         end
      endcase

      // a new start while buffer and holding slot are both full loses a frame
      if (s_reg.rst != USC_RX_IDLE && s_next.rst == USC_RX_DATA
          && s_reg.rst == USC_RX_START && s_reg.pend_v) begin
         s_next.ovr = 1'b1;
         s_next.pend_v = 1'b0;
      end else if (s_reg.rst == USC_RX_IDLE && s_next.rst == USC_RX_DATA
                   && s_reg.pend_v) begin
         s_next.ovr = 1'b1;
         s_next.pend_v = 1'b0;
      end
      if (s_next.rst == USC_RX_DATA && s_reg.rst != USC_RX_DATA) begin
         s_next.rsh = 9'h000;
         s_next.rcnt = 4'h0;
         s_next.rpe = 1'b0;
      end

      // holding slot drains first so characters keep their order
      if (s_reg.pend_v && !fifo_full) begin
         fifo_push = 1'b1;
         fifo_in = s_reg.pend;
         s_next.pend_v = 1'b0;
         if (frame_done) begin
            s_next.pend = done_char;
            s_next.pend.overrun_flag = s_next.ovr;
            s_next.pend_v = 1'b1;
         end
      end else if (frame_done) begin
         done_char.overrun_flag = s_next.ovr;
         s_next.ovr = 1'b0;
         if (!fifo_full && !s_reg.pend_v) begin
            fifo_push = 1'b1;
            fifo_in = done_char;
         end else begin
            s_next.pend = done_char;
            s_next.pend_v = 1'b1;
         end
      end

      if (!receiver_on) begin
         s_next.rst = USC_RX_IDLE;
         s_next.pend_v = 1'b0;
         s_next.ovr = 1'b0;
         fifo_flush = 1'b1;
         fifo_push = 1'b0;
      end

      // interrupt lines follow flag and enable, gated by global enable
      s_next.irq_te = ~s_next.tbuf_full & s_reg.ctrl[`USC_CT_TX_EMPTY_IRQ_EN]
                      & global_irq_enable;
      s_next.irq_td = s_next.tx_done & s_reg.ctrl[`USC_CT_TX_DONE_IRQ_EN]
                      & global_irq_enable;
      s_next.irq_rc = (~fifo_empty | fifo_push) & s_reg.ctrl[`USC_CT_RX_IRQ_EN]
                      & global_irq_enable & receiver_on;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.ctrl <= `USC_CTRL_RESET;
         s_reg.frame <= `USC_FRAME_RESET;
         s_reg.baud <= BAUD_W'(`USC_BAUD_RESET);
         s_reg.tst <= USC_TX_IDLE;
         s_reg.rst <= USC_RX_IDLE;
         s_reg.txd <= 1'b1;
         s_reg.rxd_prev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = {24'h000000, s_reg.rdata};
   assign pready = s_reg.ready;
   assign pslverr = s_reg.slverr;
   assign txd_out = s_reg.txd;
   assign txd_oe = s_reg.tx_act;
   assign rx_pin_owned = s_reg.rx_own;
   assign tx_empty_irq = s_reg.irq_te;
   assign tx_done_irq = s_reg.irq_td;
   assign rx_done_irq = s_reg.irq_rc;

endmodule // usc_serial

// file: sim/usc_peer.sv
// remote serial peer: sends frames on rxd, captures frames from txd
// assumes bit period of BIT sys_clk cycles, tasks entered after a rising edge
module usc_peer #(
   parameter int BIT = 4
) (
   input wire logic sys_clk,
   input wire logic txd_out,
   output logic rxd_in,
   output logic sync_clock_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [10:0] got;
   int got_n = 0;
   initial rxd_in = 1'b1;
   initial sync_clock_pin = 1'b0;
   // sync frame: data set with clock low, clock idles low outside frames
   task automatic send_sync(input logic [9:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         rxd_in <= b[i];
         sync_clock_pin <= 1'b0;
         repeat (2) @(posedge sys_clk);
         sync_clock_pin <= 1'b1;
         repeat (2) @(posedge sys_clk);
      end
      sync_clock_pin <= 1'b0;
   endtask
   // line idles high; extra idle gives the receiver a clean falling start edge
   task automatic send(input logic [9:0] b, input int n, input logic stp);
      rxd_in <= 1'b0;
      repeat (BIT) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         rxd_in <= b[i];
         repeat (BIT) @(posedge sys_clk);
      end
      rxd_in <= stp;
      repeat (BIT) @(posedge sys_clk);
      rxd_in <= 1'b1;
      repeat (2 * BIT) @(posedge sys_clk);
   endtask
   // mid-bit sampling of start, 8 data, parity, stop
   initial forever begin
      @(negedge txd_out);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
         got[i] = txd_out;
         if (i < 10) repeat (BIT) @(posedge sys_clk);
      end
      got_n++;
   end
endmodule // usc_peer

// file: sim/usc_serial_asserts.sv
// port checks for the serial block
// assumes bound into usc_serial, zero wait APB
`include "usc_cfg.svh"
module usc_serial_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`USC_ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic global_irq_enable,
   input wire logic tx_done_irq_ack,
   input wire logic txd_out,
   input wire logic txd_oe,
   input wire logic rx_pin_owned,
   input wire logic tx_empty_irq,
   input wire logic tx_done_irq,
   input wire logic rx_done_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire setup = psel && !penable;
   wire ctl_wr = psel && penable && pwrite && paddr == `USC_OFF_CTRL;
   chk_apb_ready: assert property (setup |=> pready)
      else $error("no ready after setup");
   chk_ready_cause: assert property (pready |-> $past(setup))
      else $error("ready without setup");
   chk_bad_addr: assert property (setup && paddr > `USC_OFF_BAUD |=> pslverr && prdata == 0)
      else $error("unmapped access not refused");
   chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_done_gate: assert property (tx_done_irq |-> $past(global_irq_enable))
      else $error("done irq without global enable");
   chk_irq_gate: assert property (tx_empty_irq || rx_done_irq |-> $past(global_irq_enable))
      else $error("irq without global enable");
   chk_ack_clear: assert property (tx_done_irq_ack |=> ##1 !tx_done_irq)
      else $error("done irq survives ack");
   chk_pin_owner: assert property ($changed(rx_pin_owned) |-> $past(ctl_wr, 2))
      else $error("rx pin owner moved without write");
   chk_pin_idle: assert property (!txd_oe |-> txd_out)
      else $error("released tx pin not idle");
   chk_start_owned: assert property ($fell(txd_out) |-> txd_oe)
      else $error("tx bit while pin released");
   cover property (tx_done_irq);
   cover property (pslverr);
   cover property ($fell(rx_pin_owned));
endmodule // usc_serial_asserts

bind usc_serial usc_serial_asserts usc_serial_asserts_i (.sys_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .global_irq_enable, .tx_done_irq_ack,
   .txd_out, .txd_oe, .rx_pin_owned, .tx_empty_irq, .tx_done_irq, .rx_done_irq);

// file: sim/usc_serial_tb.sv
// self-checking bench for the serial block over APB and the serial lines
// assumes bit period baud+1 = 4 clocks, peer model on rxd/txd
`include "usc_cfg.svh"
module usc_serial_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, slv, gie = 1, ack = 0, sck, rxd, txd, txd_oe, own, tei, rci;
   int fail_count = 0, cmp_count = 0, n0;
   always #50 sys_clk = ~sys_clk;
   usc_serial usc_serial_i (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .global_irq_enable(gie), .tx_done_irq_ack(ack),
      .sync_clock_pin(sck), .rxd_in(rxd), .txd_out(txd), .txd_oe, .rx_pin_owned(own),
      .tx_empty_irq(tei), .tx_done_irq(), .rx_done_irq(rci));
   usc_peer #(.BIT(4)) usc_peer_i (.sys_clk, .txd_out(txd), .rxd_in(rxd),
      .sync_clock_pin(sck));
   task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      // answer read mid-cycle; request held until the edge that ends it
      do @(negedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      slv = pslverr;
      @(posedge sys_clk);
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1, a, d);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, string n);
      apb(0, a, 0);
      chk(n, r & m, e);
   endtask
   task automatic wait_tx(logic [31:0] e);
      for (int i = 0; i < 400 && usc_peer_i.got_n == n0; i++) @(posedge sys_clk);
      chk("tx frame", {21'h0, usc_peer_i.got}, e);
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic conclude();
      if (fail_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      rd(`USC_OFF_CTRL, 32'hff, `USC_CTRL_RESET, "ctrl");
      rd(`USC_OFF_FRAME, 32'hff, {1'b0, `USC_FRAME_RESET}, "frame");
      rd(`USC_OFF_BAUD, 32'hff, 32'h67, "baud");
      rd(`USC_OFF_STATUS, 32'hff, 32'h20, "status reset");
      rd(8'h14, 32'hffffffff, 0, "unmapped");
      chk("slverr", slv, 1);
      wr(`USC_OFF_BAUD, 32'h3);
      wr(`USC_OFF_FRAME, 32'h26);
      wr(`USC_OFF_CTRL, 32'h78);
      @(posedge sys_clk);
      chk("rx owner", own, 1);
      chk("empty irq", tei, 1);
      gie <= 0;
      repeat (2) @(posedge sys_clk);
      chk("irq gated", tei, 0);
      gie <= 1;
      n0 = usc_peer_i.got_n;
      wr(`USC_OFF_DATA, 32'ha5);
      wait_tx({1'b1, ^8'ha5, 8'ha5, 1'b0});
      chk("done irq", usc_serial_i.tx_done_irq, 1);
      rd(`USC_OFF_STATUS, 32'hff, 32'h60, "done set");
      ack <= 1;
      @(posedge sys_clk);
      ack <= 0;
      repeat (2) @(posedge sys_clk);
      rd(`USC_OFF_STATUS, 32'hff, 32'h20, "ack clear");
      n0 = usc_peer_i.got_n;
      wr(`USC_OFF_DATA, 32'h3c);
      wr(`USC_OFF_CTRL, 32'h50);
      chk("drain oe", txd_oe, 1);
      wait_tx({1'b1, ^8'h3c, 8'h3c, 1'b0});
      chk("released oe", txd_oe, 0);
      rd(`USC_OFF_STATUS, 32'hff, 32'h60, "done drained");
      wr(`USC_OFF_STATUS, 32'h40);
      rd(`USC_OFF_STATUS, 32'hff, 32'h20, "w1c");
      usc_peer_i.send({1'b0, 8'h11}, 9, 0);
      usc_peer_i.send({1'b1, 8'h22}, 9, 1);
      usc_peer_i.send({1'b0, 8'h33}, 9, 1);
      usc_peer_i.send({1'b0, 8'h44}, 9, 1);
      rd(`USC_OFF_STATUS, 32'h9c, 32'h90, "fe entry");
      rd(`USC_OFF_DATA, 32'hff, 32'h11, "rx 1");
      rd(`USC_OFF_STATUS, 32'h9c, 32'h84, "pe entry");
      rd(`USC_OFF_DATA, 32'hff, 32'h22, "rx 2");
      rd(`USC_OFF_STATUS, 32'h9c, 32'h88, "dor entry");
      rd(`USC_OFF_DATA, 32'hff, 32'h44, "rx 4");
      rd(`USC_OFF_STATUS, 32'h80, 0, "rx empty");
      wr(`USC_OFF_CTRL, 32'h54);
      usc_peer_i.send({1'b1, 9'h1a5}, 10, 1);
      rd(`USC_OFF_CTRL, 32'hff, 32'h56, "ninth bit");
      rd(`USC_OFF_DATA, 32'hff, 32'ha5, "low byte");
      wr(`USC_OFF_CTRL, 32'hd0);
      wr(`USC_OFF_FRAME, 32'h44);
      usc_peer_i.send_sync({1'b1, 7'h5a, 1'b0}, 9);
      chk("rx irq", rci, 1);
      rd(`USC_OFF_STATUS, 32'h90, 32'h80, "sync status");
      rd(`USC_OFF_DATA, 32'hff, 32'h5a, "sync narrow rx");
      @(posedge sys_clk);
      chk("rx irq clear", rci, 0);
      wr(`USC_OFF_FRAME, 32'h26);
      usc_peer_i.send({1'b0, 8'h11}, 9, 1);
      wr(`USC_OFF_CTRL, 32'h00);
      rd(`USC_OFF_STATUS, 32'h80, 0, "flushed");
      chk("rx released", own, 0);
      chk("rx irq off", rci, 0);
      conclude();
   end
endmodule // usc_serial_tb
